// File: ddr3_command_spacing_timer_bench.sv
// self-checking bench: controller end and device end joined by the link
// assumes speed bin 0; spacing is measured between req_done_o pulses, or from reset release to the first one
`timescale 1ns/1ns
module ddr3_command_spacing_timer_bench;
    import ddr3_spacing_pkg::*;

    logic clk, reset_n, req_valid, req_pat, req_done, rdata_valid, ctl_busy, dev_busy, pat_mode;
    cmd_e req_cmd;
    logic [2:0] req_bank;
    logic [DQ_W-1:0] req_wdata, rdata;
    int fail_count, num_checks, gap, cycles;
    time t_last;

    ddr3_link_if link();

    ddr3_ctl_end ddr3_ctl_end_i (.core_clk_i(clk), .reset_n_i(reset_n), .req_valid_i(req_valid),
        .req_cmd_i(req_cmd), .req_bank_i(req_bank), .req_pat_mode_i(req_pat),
        .req_wdata_i(req_wdata), .req_done_o(req_done), .rdata_o(rdata),
        .rdata_valid_o(rdata_valid), .cal_busy_o(ctl_busy), .link(link));
    ddr3_dev_end ddr3_dev_end_i (.core_clk_i(clk), .reset_n_i(reset_n), .link(link),
        .cal_busy_o(dev_busy), .pat_mode_o(pat_mode));
    ddr3_link_checker ddr3_link_checker_i (.core_clk_i(clk), .reset_n_i(reset_n),
        .cmd(link.cmd), .ctl_dqs_oe(link.ctl_dqs_oe), .ctl_dq_oe(link.ctl_dq_oe),
        .dev_dqs_oe(link.dev_dqs_oe), .dev_dq_oe(link.dev_dq_oe), .dqs(link.dqs));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up;
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    // request held until done; gap counts cycles since the previous done, or since reset release after do_reset
    task automatic issue(input cmd_e c, input logic [2:0] b, input logic m,
                         input logic [DQ_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_bank <= b;
        req_pat <= m;
        req_wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (req_done !== 1'b1 && n < 1000);
        req_valid <= 1'b0;
        gap = int'(($time - t_last) / 40);
        t_last = $time;
        chk(n < 1000, "request never done");
    endtask

    task automatic gaps(input int lo, input int hi);
        chk(gap >= lo && gap <= hi, "command spacing");
    endtask

    task automatic beats(input logic [DQ_W-1:0] e);
        int k;
        k = 0;
        repeat (12) begin
            @(posedge clk);
            if (rdata_valid === 1'b1) begin
                k++;
                chk(rdata === e, "read data");
            end
        end
        chk(k == 4, "beat count");
    endtask

    task automatic do_reset(input int n);
        reset_n <= 1'b0;
        repeat (n) @(posedge clk);
        chk(ctl_busy === 1'b1 && dev_busy === 1'b1, "busy in reset");
        reset_n <= 1'b1;
        t_last = $time;
        issue(CMD_ACT, 3'h0, 1'b0, 16'h0000);
        gaps(513, 514);
        chk(dev_busy === 1'b0 && ctl_busy === 1'b0, "calibration end");
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            chk(1'b0, "timeout");
            wrap_up();
        end
    end

    initial begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req_cmd = CMD_NOP;
        req_bank = 3'h0;
        req_pat = 1'b0;
        req_wdata = '0;
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        do_reset(16);
        issue(CMD_ACT, 3'h1, 1'b0, 16'h0000);
        gaps(6, 8);
        issue(CMD_WR, 3'h0, 1'b0, 16'h1234);
        issue(CMD_RD, 3'h0, 1'b0, 16'h0000);
        gaps(15, 17);
        fork
            beats(16'h1234);
            begin
                issue(CMD_PRE, 3'h0, 1'b0, 16'h0000);
                gaps(4, 6);
            end
        join
        issue(CMD_WRA, 3'h1, 1'b0, 16'hbeef);
        issue(CMD_ACT, 3'h1, 1'b0, 16'h0000);
        gaps(33, 35);
        issue(CMD_RD, 3'h1, 1'b0, 16'h0000);
        beats(16'hbeef);
        issue(CMD_MRS, 3'h0, 1'b1, 16'h0000);
        issue(CMD_RD, 3'h1, 1'b0, 16'h0000);
        gaps(12, 14);
        chk(pat_mode === 1'b1, "register mode on");
        fork
            beats(PAT_WORD);
            begin
                issue(CMD_MRS, 3'h0, 1'b0, 16'h0000);
                gaps(11, 13);
            end
        join
        issue(CMD_MRS, 3'h0, 1'b0, 16'h0000);
        gaps(4, 6);
        chk(pat_mode === 1'b0, "register mode off");
        issue(CMD_PRE, 3'h1, 1'b0, 16'h0000);
        issue(CMD_ZQS, 3'h0, 1'b0, 16'h0000);
        issue(CMD_ACT, 3'h2, 1'b0, 16'h0000);
        gaps(64, 66);
        issue(CMD_PRE, 3'h2, 1'b0, 16'h0000);
        issue(CMD_ZQL, 3'h0, 1'b0, 16'h0000);
        issue(CMD_ACT, 3'h3, 1'b0, 16'h0000);
        gaps(256, 258);
        issue(CMD_PRE, 3'h3, 1'b0, 16'h0000);
        issue(CMD_REF, 3'h0, 1'b0, 16'h0000);
        @(posedge clk);
        chk(req_done === 1'b0, "request taken twice");
        do_reset(2);
        wrap_up();
    end
endmodule

// File: ddr3_ctl_end.sv
// controller end: issues user commands on the link only once every
// spacing since earlier commands has run out; frames write strobes
// assumes the device end answers reads with the same latency settings
`timescale 1ns/1ns

module ddr3_ctl_end #(
    parameter int SPEED_BIN = 0,
    parameter int RD_LAT = ddr3_spacing_pkg::RD_LAT_DEF,
    parameter int WR_LAT = ddr3_spacing_pkg::WR_LAT_DEF,
    parameter int BURST_LEN = ddr3_spacing_pkg::BURST_LEN_DEF
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // command request, held until done
    input wire logic req_valid_i,
    input wire ddr3_spacing_pkg::cmd_e req_cmd_i,
    input wire logic [2:0] req_bank_i,
    input wire logic req_pat_mode_i,
    input wire logic [ddr3_spacing_pkg::DQ_W-1:0] req_wdata_i,
    output logic req_done_o,
    // read return
    output logic [ddr3_spacing_pkg::DQ_W-1:0] rdata_o,
    output logic rdata_valid_o,
    // status
    output logic cal_busy_o,
    // link
    ddr3_link_if.ctl link
);
    import ddr3_spacing_pkg::*;

    localparam int BL2 = BURST_LEN / 2;
    localparam int RTP_C = imax(RTP_MIN_NCK, ns_cyc(RTP_PS));
    localparam int MOD_C = imax(MOD_MIN_NCK, ns_cyc(MOD_PS));
    localparam int RCD_C = ns_cyc(RCD_PS[SPEED_BIN]);
    localparam int RC_C = ns_cyc(RC_PS[SPEED_BIN]);
    localparam int RAS_C = ns_cyc(RAS_PS[SPEED_BIN]);
    localparam int FAW_C = ns_cyc(FAW_PS);
    localparam int WR_C = ns_cyc(WR_PS);
    // write data ends this many cycles after the write command
    localparam int WEND_C = WR_LAT + BL2;

    typedef struct packed {
        logic [BANKS-1:0] open;
        cnt_t [BANKS-1:0] rcd;
        cnt_t [BANKS-1:0] ras;
        cnt_t [BANKS-1:0] rc;
        cnt_t [BANKS-1:0] rtp;
        cnt_t [BANKS-1:0] wrp;
        cnt_t rrd;
        cnt_t ccd;
        cnt_t wtr;
        cnt_t mrd;
        cnt_t mod;
        cnt_t mprr;
        cnt_t zq;
        cnt_t wl;
        cnt_t rd_win;
        cnt_t [3:0] faw;
        logic [1:0] faw_ptr;
        cmd_e cmd;
        logic [2:0] bank;
        logic pat_mode;
        logic done;
        logic [DQ_W-1:0] wdata;
        logic [DQ_W-1:0] rdata;
        logic rvalid;
        logic dqs;
        logic dqs_oe;
        logic dq_oe;
        logic busy;
    } ctl_s;

    ctl_s s_ff;
    ctl_s nxt_s;

    always_comb begin
        logic ok;
        logic all_idle;
        logic [2:0] b;
        ok = 1'b0;
        all_idle = 1'b1;
        b = req_bank_i;
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.rvalid = 1'b0;
        nxt_s.cmd = CMD_NOP;
        for (int i = 0; i < BANKS; i++) begin
            nxt_s.rcd[i] = dec(s_ff.rcd[i]);
            nxt_s.ras[i] = dec(s_ff.ras[i]);
            nxt_s.rc[i] = dec(s_ff.rc[i]);
            nxt_s.rtp[i] = dec(s_ff.rtp[i]);
            nxt_s.wrp[i] = dec(s_ff.wrp[i]);
            if (s_ff.open[i] || s_ff.rc[i] != '0) begin
                all_idle = 1'b0;
            end
        end
        for (int i = 0; i < 4; i++) begin
            nxt_s.faw[i] = dec(s_ff.faw[i]);
        end
        nxt_s.rrd = dec(s_ff.rrd);
        nxt_s.ccd = dec(s_ff.ccd);
        nxt_s.wtr = dec(s_ff.wtr);
        nxt_s.mrd = dec(s_ff.mrd);
        nxt_s.mod = dec(s_ff.mod);
        nxt_s.mprr = dec(s_ff.mprr);
        nxt_s.zq = dec(s_ff.zq);
        nxt_s.wl = dec(s_ff.wl);
        nxt_s.rd_win = dec(s_ff.rd_win);

        // legality of the held request against every running spacing
        case (req_cmd_i)
            CMD_NOP: begin
                ok = 1'b1;
            end
            CMD_ACT: begin
                ok = !s_ff.open[b] && s_ff.rc[b] == '0
                    && s_ff.rrd == '0
                    && s_ff.faw[s_ff.faw_ptr] == '0;
            end
            CMD_RD: begin
                ok = s_ff.open[b] && s_ff.rcd[b] == '0 && s_ff.ccd == '0
                    && s_ff.wtr == '0 && s_ff.wl == '0 && s_ff.rd_win == '0;
            end
            CMD_WR, CMD_WRA: begin
                ok = s_ff.open[b] && s_ff.rcd[b] == '0 && s_ff.ccd == '0
                    && s_ff.wl == '0 && s_ff.rd_win == '0;
            end
            CMD_PRE: begin
                ok = s_ff.ras[b] == '0 && s_ff.rtp[b] == '0
                    && s_ff.wrp[b] == '0;
            end
            CMD_REF: begin
                ok = all_idle;
            end
            CMD_MRS: begin
                ok = s_ff.mrd == '0 && s_ff.mprr == '0;
            end
            CMD_ZQL, CMD_ZQS: begin
                ok = all_idle;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        // nothing but mode sets until the mode update settles
        if (req_cmd_i != CMD_MRS && req_cmd_i != CMD_NOP && s_ff.mod != '0) begin
            ok = 1'b0;
        end
        if (s_ff.zq != '0) begin
            ok = 1'b0;
        end

        if (req_valid_i && ok && !s_ff.done) begin // requester holds through done
            nxt_s.done = 1'b1;
            nxt_s.cmd = req_cmd_i;
            nxt_s.bank = b;
            case (req_cmd_i)
                CMD_ACT: begin
                    nxt_s.open[b] = 1'b1;
                    nxt_s.rcd[b] = ld(RCD_C);
                    nxt_s.ras[b] = ld(RAS_C);
                    nxt_s.rc[b] = ld(RC_C);
                    nxt_s.rrd = ld(RRD_NCK[SPEED_BIN]);
                    nxt_s.faw[s_ff.faw_ptr] = ld(FAW_C);
                    nxt_s.faw_ptr = s_ff.faw_ptr + 2'h1;
                end
                CMD_RD: begin
                    nxt_s.rtp[b] = ld(RTP_C);
                    nxt_s.ccd = ld(CCD_NCK);
                    nxt_s.rd_win = cnt_t'(RD_LAT + BL2 + 1);
                    if (s_ff.pat_mode) begin
                        nxt_s.mprr = ld(RD_LAT + BL2 + MPRR_NCK);
                    end
                end
                CMD_WR, CMD_WRA: begin
                    nxt_s.ccd = ld(CCD_NCK);
                    nxt_s.wtr = ld(WEND_C + WTR_NCK[SPEED_BIN]);
                    nxt_s.wrp[b] = ld(WEND_C + WR_C);
                    nxt_s.wl = cnt_t'(WEND_C + 1);
                    nxt_s.wdata = req_wdata_i;
                    if (req_cmd_i == CMD_WRA) begin
                        // bank closes by itself; no reopen until recovery ends
                        nxt_s.open[b] = 1'b0;
                        nxt_s.rc[b] = ld(WEND_C + DAL_NCK[SPEED_BIN]);
                    end
                end
                CMD_PRE: begin
                    nxt_s.open[b] = 1'b0;
                end
                CMD_MRS: begin
                    nxt_s.mrd = ld(MRD_NCK);
                    nxt_s.mod = ld(MOD_C);
                    nxt_s.pat_mode = req_pat_mode_i;
                end
                CMD_ZQL: begin
                    nxt_s.zq = ld(ZQ_LONG_NCK);
                end
                CMD_ZQS: begin
                    nxt_s.zq = ld(ZQ_SHORT_NCK);
                end
                default: begin
                end
            endcase
        end

        // write strobe: preamble, data beats, postamble, each a whole cycle
        nxt_s.dqs_oe = (nxt_s.wl != '0) && (nxt_s.wl <= cnt_t'(BL2 + 2));
        // strobe rises on the core edge that launches the data
        nxt_s.dqs = (nxt_s.wl >= cnt_t'(2)) && (nxt_s.wl <= cnt_t'(BL2 + 1));
        nxt_s.dq_oe = nxt_s.dqs;

        if (s_ff.rd_win >= cnt_t'(2) && s_ff.rd_win <= cnt_t'(BL2 + 1) && link.dqs) begin
            nxt_s.rdata = link.dq;
            nxt_s.rvalid = 1'b1;
        end
        nxt_s.busy = (nxt_s.zq != '0);
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_ff <= '0;
            s_ff.zq <= cnt_t'(ZQ_INIT_NCK - 1);
            s_ff.busy <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign link.cmd = s_ff.cmd;
    assign link.bank = s_ff.bank;
    assign link.pat_mode = s_ff.pat_mode;
    assign link.ctl_dqs = s_ff.dqs;
    assign link.ctl_dqs_oe = s_ff.dqs_oe;
    assign link.ctl_dq = s_ff.wdata;
    assign link.ctl_dq_oe = s_ff.dq_oe;
    assign req_done_o = s_ff.done;
    assign rdata_o = s_ff.rdata;
    assign rdata_valid_o = s_ff.rvalid;
    assign cal_busy_o = s_ff.busy;
endmodule

// File: ddr3_dev_end.sv
// device end: calibration busy time, read strobe framing, write capture
// assumes the controller end keeps the command spacing on the link
`timescale 1ns/1ns
module ddr3_dev_end #(
    parameter int RD_LAT = ddr3_spacing_pkg::RD_LAT_DEF,
    parameter int WR_LAT = ddr3_spacing_pkg::WR_LAT_DEF,
    parameter int BURST_LEN = ddr3_spacing_pkg::BURST_LEN_DEF
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // link
    ddr3_link_if.dev link,
    // status
    output logic cal_busy_o,
    output logic pat_mode_o
);
    import ddr3_spacing_pkg::*;

    localparam int BL2 = BURST_LEN / 2;

    typedef struct packed {
        cnt_t cal;
        cnt_t dr;
        cnt_t dw;
        logic [2:0] rbank;
        logic [2:0] wbank;
        logic pat_mode;
        logic [BANKS-1:0][DQ_W-1:0] mem;
        logic dqs;
        logic dqs_oe;
        logic dq_oe;
        logic [DQ_W-1:0] dq;
        logic busy;
    } dev_s;

    dev_s s_ff;
    dev_s nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.cal = dec(s_ff.cal);
        nxt_s.dr = dec(s_ff.dr);
        nxt_s.dw = dec(s_ff.dw);
        // commands that arrive during calibration are ignored
        if (s_ff.cal == '0) begin
            case (link.cmd)
                CMD_RD: begin
                    nxt_s.dr = cnt_t'(RD_LAT + BL2);
                    nxt_s.rbank = link.bank;
                end
                CMD_WR, CMD_WRA: begin
                    nxt_s.dw = cnt_t'(WR_LAT + BL2);
                    nxt_s.wbank = link.bank;
                end
                CMD_MRS: begin
                    nxt_s.pat_mode = link.pat_mode;
                end
                CMD_ZQL: begin
                    nxt_s.cal = ld(ZQ_LONG_NCK);
                end
                CMD_ZQS: begin
                    nxt_s.cal = ld(ZQ_SHORT_NCK);
                end
                default: begin
                end
            endcase
        end
        if (s_ff.dw >= cnt_t'(2) && s_ff.dw <= cnt_t'(BL2 + 1) && link.dqs) begin
            nxt_s.mem[s_ff.wbank] = link.dq;
        end
        // drive from read_latency - 1 (preamble) through the postamble cycle
        nxt_s.dqs_oe = (nxt_s.dr != '0) && (nxt_s.dr <= cnt_t'(BL2 + 2));
        nxt_s.dqs = (nxt_s.dr >= cnt_t'(2)) && (nxt_s.dr <= cnt_t'(BL2 + 1));
        // last driven cycle holds the strobe low as postamble
        nxt_s.dq_oe = nxt_s.dqs;
        nxt_s.dq = nxt_s.pat_mode ? PAT_WORD : nxt_s.mem[nxt_s.rbank];
        nxt_s.busy = (nxt_s.cal != '0);
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_ff <= '0;
            s_ff.cal <= cnt_t'(ZQ_INIT_NCK);
            s_ff.busy <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign link.dev_dqs = s_ff.dqs;
    assign link.dev_dqs_oe = s_ff.dqs_oe;
    assign link.dev_dq = s_ff.dq;
    assign link.dev_dq_oe = s_ff.dq_oe;
    assign cal_busy_o = s_ff.busy;
    assign pat_mode_o = s_ff.pat_mode;
endmodule

// File: ddr3_link_checker.sv
// checker for the ddr3 link: command spacing, calibration hold-off, strobe framing
// assumes speed bin 0, read latency 6, write latency 5, burst of four beats
`timescale 1ns/1ns
module ddr3_link_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // link
    input wire ddr3_spacing_pkg::cmd_e cmd,
    input wire logic ctl_dqs_oe,
    input wire logic ctl_dq_oe,
    input wire logic dev_dqs_oe,
    input wire logic dev_dq_oe,
    input wire logic dqs
);
    import ddr3_spacing_pkg::*;

    // cycles since reset and since each read, write, mode set and calibration command, saturating so old history never wraps
    logic [9:0] boot_ff, rd_ff, wr_ff, mrs_ff, zq_ff;
    logic [8:0] zq_len_ff;

    function automatic logic [9:0] up(input logic [9:0] c);
        return (c == 10'h3ff) ? c : c + 10'h001;
    endfunction

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            boot_ff <= '0;
            rd_ff <= '1;
            wr_ff <= '1;
            mrs_ff <= '1;
            zq_ff <= '1;
            zq_len_ff <= '0;
        end else begin
            boot_ff <= up(boot_ff);
            rd_ff <= (cmd == CMD_RD) ? 10'h001 : up(rd_ff);
            wr_ff <= (cmd inside {CMD_WR, CMD_WRA}) ? 10'h001 : up(wr_ff);
            mrs_ff <= (cmd == CMD_MRS) ? 10'h001 : up(mrs_ff);
            zq_ff <= (cmd inside {CMD_ZQL, CMD_ZQS}) ? 10'h001 : up(zq_ff);
            if (cmd == CMD_ZQL) begin
                zq_len_ff <= 9'h100;
            end else if (cmd == CMD_ZQS) begin
                zq_len_ff <= 9'h040;
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_init;
        cmd != CMD_NOP |-> boot_ff >= 10'h200;
    endproperty
    a_init: assert property (p_init) else $error("command during power-up calibration");

    property p_zq;
        cmd != CMD_NOP |-> zq_ff >= {1'b0, zq_len_ff};
    endproperty
    a_zq: assert property (p_zq) else $error("command during calibration");

    property p_mrd;
        cmd == CMD_MRS |=> (cmd != CMD_MRS) [*3];
    endproperty
    a_mrd: assert property (p_mrd) else $error("mode sets too close");

    property p_mod;
        !(cmd inside {CMD_NOP, CMD_MRS}) |-> mrs_ff >= 10'h00c;
    endproperty
    a_mod: assert property (p_mod) else $error("command during mode update");

    property p_ccd;
        cmd inside {CMD_RD, CMD_WR, CMD_WRA} |=> !(cmd inside {CMD_RD, CMD_WR, CMD_WRA}) [*3];
    endproperty
    a_ccd: assert property (p_ccd) else $error("column commands too close");

    property p_rrd;
        cmd == CMD_ACT |=> (cmd != CMD_ACT) [*5];
    endproperty
    a_rrd: assert property (p_rrd) else $error("activates too close");

    property p_rtp;
        cmd == CMD_PRE |-> rd_ff >= 10'h004;
    endproperty
    a_rtp: assert property (p_rtp) else $error("precharge too soon after read");

    property p_wtr;
        cmd == CMD_RD |-> wr_ff >= 10'h00f;
    endproperty
    a_wtr: assert property (p_wtr) else $error("read too soon after write");

    // whole-cycle pre and postamble stand for the fractional minimums
    property p_wframe;
        cmd inside {CMD_WR, CMD_WRA} |-> ##4 (ctl_dqs_oe && !dqs)
            ##1 (ctl_dqs_oe && dqs && ctl_dq_oe) [*4] ##1 (ctl_dqs_oe && !dqs) ##1 !ctl_dqs_oe;
    endproperty
    a_wframe: assert property (p_wframe) else $error("write strobe framing");

    property p_rframe;
        cmd == CMD_RD |-> ##5 (dev_dqs_oe && !dqs)
            ##1 (dev_dqs_oe && dqs && dev_dq_oe) [*4] ##1 (dev_dqs_oe && !dqs) ##1 !dev_dqs_oe;
    endproperty
    a_rframe: assert property (p_rframe) else $error("read strobe framing");

    c_wra: cover property (cmd == CMD_WRA);
    c_rd: cover property (cmd == CMD_RD);
    c_zql: cover property (cmd == CMD_ZQL);
endmodule

// File: ddr3_link_if.sv
// command, strobe and data wires between controller end and device end
// the shared strobe and data wires are resolved here from both enables
`timescale 1ns/1ns
interface ddr3_link_if;
    import ddr3_spacing_pkg::*;

    cmd_e cmd;
    logic [2:0] bank;
    logic pat_mode;
    logic ctl_dqs;
    logic ctl_dqs_oe;
    logic [DQ_W-1:0] ctl_dq;
    logic ctl_dq_oe;
    logic dev_dqs;
    logic dev_dqs_oe;
    logic [DQ_W-1:0] dev_dq;
    logic dev_dq_oe;
    logic dqs;
    logic [DQ_W-1:0] dq;

    // an undriven strobe reads low, undriven data reads zero
    assign dqs = ctl_dqs_oe ? ctl_dqs : (dev_dqs_oe & dev_dqs);
    assign dq = ctl_dq_oe ? ctl_dq : (dev_dq_oe ? dev_dq : '0);

    modport ctl (
        output cmd, bank, pat_mode, ctl_dqs, ctl_dqs_oe, ctl_dq, ctl_dq_oe,
        input dqs, dq
    );

    modport dev (
        input cmd, bank, pat_mode, dqs, dq,
        output dev_dqs, dev_dqs_oe, dev_dq, dev_dq_oe
    );
endinterface

// File: ddr3_spacing_pkg.sv
// shared types and timing figures for the ddr3 command spacing ends
// assumes one 25 MHz core clock on both ends of the link
package ddr3_spacing_pkg;

    // core clock period in picoseconds
    localparam int CLK_PS = 40000;

    localparam int BANKS = 8;
    localparam int DQ_W = 16;
    localparam int CW = 10;

    typedef logic [CW-1:0] cnt_t;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_ACT = 4'h1,
        CMD_RD = 4'h2,
        CMD_WR = 4'h3,
        CMD_WRA = 4'h4,
        CMD_PRE = 4'h5,
        CMD_REF = 4'h6,
        CMD_MRS = 4'h7,
        CMD_ZQL = 4'h8,
        CMD_ZQS = 4'h9
    } cmd_e;

    // default latencies and burst
    localparam int RD_LAT_DEF = 6;
    localparam int WR_LAT_DEF = 5;
    localparam int BURST_LEN_DEF = 8;

    // figures per speed bin: 800, 900, 1000 MHz
    localparam int RTP_MIN_NCK = 4;
    localparam int RTP_PS = 7500;
    localparam int WTR_NCK [3] = '{6, 7, 8};
    localparam int WR_PS = 15000;
    localparam int MRD_NCK = 4;
    localparam int MOD_MIN_NCK = 12;
    localparam int MOD_PS = 15000;
    localparam int RCD_PS [3] = '{15000, 15400, 15000};
    localparam int RC_PS [3] = '{50000, 49500, 50000};
    localparam int CCD_NCK = 4;
    localparam int DAL_NCK [3] = '{24, 28, 30};
    localparam int MPRR_NCK = 1;
    localparam int RAS_PS [3] = '{35000, 35200, 35000};
    localparam int RRD_NCK [3] = '{6, 7, 8};
    localparam int FAW_PS = 40000;
    localparam int ZQ_INIT_NCK = 512;
    localparam int ZQ_LONG_NCK = 256;
    localparam int ZQ_SHORT_NCK = 64;

    // fixed read pattern while the multi_purpose_register is selected
    localparam logic [DQ_W-1:0] PAT_WORD = 16'h55aa;

    // least time rounded up to whole cycles, never below one
    function automatic int ns_cyc(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // counter load for a spacing of n cycles between issue edges
    function automatic cnt_t ld(input int n);
        return cnt_t'(n - 1);
    endfunction

    function automatic cnt_t dec(input cnt_t c);
        return (c == '0) ? '0 : cnt_t'(c - 1'b1);
    endfunction

endpackage
